// ---- design/event_mask_pkg.sv ----
// ============================================================
// Event mask bank constants
package event_mask_pkg;

  // ============================================================
  // Widths
  localparam int ADDR_W     = 12;                 // Avalon byte address width
  localparam int DATA_W     = 32;                 // Avalon data width
  localparam int MASK_W     = 8;                  // Width of one mask byte
  localparam int MASK_COUNT = 15;                 // Mask bytes in the bank
  localparam int SLOT_W     = 4;                  // Width of a slot number
  localparam int EVENT_W    = MASK_W * MASK_COUNT; // Event lanes in total

  // ============================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CLOCK_WDOG_EEPROM = 10'h10f; // clock_watchdog_eeprom_event_enable
  localparam logic [9:0] IDX_REF_AB            = 10'h110; // ref_ab_event_enable
  localparam logic [9:0] IDX_REF_CD            = 10'h111; // ref_cd_event_enable
  localparam logic [9:0] IDX_LOOP0_LOCK        = 10'h112; // loop0_lock_event_enable
  localparam logic [9:0] IDX_LOOP0_MODE        = 10'h113; // loop0_mode_event_enable
  localparam logic [9:0] IDX_LOOP0_MISC        = 10'h114; // loop0_misc_event_enable
  localparam logic [9:0] IDX_LOOP1_FIRST       = 10'h115; // Loop 1 lock byte
  localparam logic [9:0] IDX_LAST              = 10'h11d; // Loop 3 misc byte
  localparam int         LOOP_BYTES            = 3;       // Mask bytes per digital loop

  // Paired monitor byte address of slot 0
  localparam logic [15:0] MONITOR_BASE = 16'h0d08;
  localparam logic [15:0] MONITOR_LAST = 16'h0d16;

  // ============================================================
  // Reset value and reserved bits
  localparam logic [MASK_W-1:0] MASK_RESET   = 8'h00;
  localparam logic [MASK_W-1:0] REF_WRITABLE = 8'h77; // Bits 7 and 3 reserved
  localparam logic [MASK_W-1:0] ALL_WRITABLE = 8'hff;
  localparam logic [SLOT_W-1:0] SLOT_REF_AB  = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_REF_CD  = 4'h2;

  // ============================================================
  // Field positions: clock, watchdog and EEPROM byte
  localparam int B_CLK_UNLOCKED   = 7;
  localparam int B_CLK_STABLE     = 6;
  localparam int B_CLK_LOCKED     = 5;
  localparam int B_CLK_CAL_END    = 4;
  localparam int B_CLK_CAL_START  = 3;
  localparam int B_WDOG_EXPIRED   = 2;
  localparam int B_EEPROM_FAULT   = 1;
  localparam int B_EEPROM_DONE    = 0;
  // Reference bytes: input A/C low nibble, B/D high nibble
  localparam int B_REF_FAULT      = 0;
  localparam int B_REF_CLEARED    = 1;
  localparam int B_REF_VALID      = 2;
  localparam int REF_HI_SHIFT     = 4;
  // Loop lock byte
  localparam int B_FREQ_UNCLAMPED = 7;
  localparam int B_FREQ_CLAMPED   = 6;
  localparam int B_SLEW_UNLIMITED = 5;
  localparam int B_SLEW_LIMITED   = 4;
  localparam int B_FREQ_UNLOCKED  = 3;
  localparam int B_FREQ_LOCKED    = 2;
  localparam int B_PHASE_UNLOCKED = 1;
  localparam int B_PHASE_LOCKED   = 0;
  // Loop mode byte
  localparam int B_SWITCHING      = 7;
  localparam int B_FREE_RUN       = 6;
  localparam int B_HOLDOVER       = 5;
  localparam int B_HISTORY        = 4;
  localparam int B_REF_ACTIVE_A   = 0;  // A..D in bits 0..3
  // Loop misc byte
  localparam int B_PHASE_STEP     = 7;
  localparam int B_DEMAP_UNCLAMP  = 6;
  localparam int B_DEMAP_CLAMP    = 5;
  localparam int B_DIST_SYNC      = 4;
  localparam int B_ALOOP_UNLOCKED = 3;
  localparam int B_ALOOP_LOCKED   = 2;
  localparam int B_ALOOP_CAL_DONE = 1;
  localparam int B_ALOOP_CAL_GO   = 0;

  // ============================================================
  // Avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECODE = 2'b11;

  // Bus answer state, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage : event_mask_pkg

// ---- design/interrupt_event_mask_bank.sv ----
`timescale 1ns/1ps
module interrupt_event_mask_bank (
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   reset_n,
  // Avalon-MM slave
  input  wire logic [event_mask_pkg::ADDR_W-1:0]      address,
  input  wire logic                                   read,
  input  wire logic                                   write,
  input  wire logic [3:0]                             byteenable,
  input  wire logic [event_mask_pkg::DATA_W-1:0]      writedata,
  output logic      [event_mask_pkg::DATA_W-1:0]      readdata,
  output logic      [1:0]                             response,
  output logic                                        waitrequest,
  // Raw event pulses, one lane per monitor bit
  input  wire logic [event_mask_pkg::EVENT_W-1:0]     eventIn,
  // Gated events towards the monitor registers
  output logic      [event_mask_pkg::EVENT_W-1:0]     monitorSet
);
  import event_mask_pkg::*;

  // ============================================================
  // Helper functions

  // True when the byte address lands on a mask byte
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    isMapped = (addr[1:0] == 2'b00) && (idx >= IDX_CLOCK_WDOG_EEPROM) && (idx <= IDX_LAST);
  endfunction : isMapped

  // Slot number within the bank for a mapped address
  function automatic logic [SLOT_W-1:0] slotOf(input logic [ADDR_W-1:0] addr);
    logic [9:0] diff;
    diff = addr[ADDR_W-1:2] - IDX_CLOCK_WDOG_EEPROM;
    slotOf = diff[SLOT_W-1:0];
  endfunction : slotOf

  // Bits that software may set in a slot; reserved bits stay zero
  function automatic logic [MASK_W-1:0] writableBits(input logic [SLOT_W-1:0] slot);
    if (slot == SLOT_REF_AB || slot == SLOT_REF_CD) begin
      writableBits = REF_WRITABLE;
    end else begin
      writableBits = ALL_WRITABLE;
    end
  endfunction : writableBits

  // Slot of a word index within the bank
  function automatic int slotNum(input logic [9:0] idx);
    slotNum = int'(idx - IDX_CLOCK_WDOG_EEPROM);
  endfunction : slotNum

  // Event lane of bit b in the mask byte at word index idx
  function automatic int laneOf(input logic [9:0] idx, input int b);
    laneOf = slotNum(idx) * MASK_W + b;
  endfunction : laneOf

  // ============================================================
  // Storage

  logic [MASK_W-1:0]  maskReg [MASK_COUNT];  // Enable bytes, slot 0 = index 0x10f
  logic [EVENT_W-1:0] maskFlat;              // Enable bytes laid out as event lanes
  bus_state_t         busState;              // Bus answer state
  logic               accepted;              // Request taken at this edge
  logic               reqMapped;             // Current address hits a mask byte
  logic [SLOT_W-1:0]  reqSlot;               // Slot addressed by the request

  assign reqMapped = isMapped(address);
  assign reqSlot   = slotOf(address);
  assign accepted  = (read || write) && !waitrequest;

  // Flatten the bank so lane 8*k+b pairs monitor byte k, bit b
  always_comb begin
    for (int k = 0; k < MASK_COUNT; k++) begin
      maskFlat[k*MASK_W +: MASK_W] = maskReg[k];
    end
  end

  // ============================================================
  // Bus answer sequencing

  // One wait cycle, then the answer edge, then idle again
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busState    <= BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (busState)
        // Request seen: drop waitrequest for the next edge
        BUS_IDLE: begin
          if (read || write) begin
            busState    <= BUS_ANSWER;
            waitrequest <= 1'b0;
          end
        end
        // Request taken at this edge: raise waitrequest again
        BUS_ANSWER: begin
          busState    <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
        // Recover from an illegal code
        default: begin
          busState    <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data and response, ready before the answer edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      readdata <= '0;
      response <= RESP_OKAY;
    end else if (busState == BUS_IDLE && (read || write)) begin
      if (reqMapped) begin
        // Byte in the low lane, upper bits read zero
        readdata <= {{(DATA_W-MASK_W){1'b0}}, maskReg[reqSlot]};
        response <= RESP_OKAY;
      end else begin
        // Unmapped: zero data and a decode error
        readdata <= '0;
        response <= RESP_DECODE;
      end
    end
  end

  // ============================================================
  // Enable bytes

  // Writes land on the answer edge; reserved bits forced to zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int k = 0; k < MASK_COUNT; k++) begin
        maskReg[k] <= MASK_RESET;
      end
    end else if (write && accepted && reqMapped && byteenable[0]) begin
      // Same layout in every loop group
      maskReg[reqSlot] <= writedata[MASK_W-1:0] & writableBits(reqSlot);
    end
  end

  // ============================================================
  // Event gating

  // Each event lane passes only while its enable bit is one
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      monitorSet <= '0;
    end else begin
      // Lane positions
      monitorSet <= eventIn & maskFlat;
    end
  end

  // ============================================================
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // A request is held while waitrequest stays high
  sequence seq_request;
    (read || write) && waitrequest;
  endsequence

  // The answer edge of a request
  sequence seq_answer;
    (read || write) && !waitrequest;
  endsequence

  chk_answer_time: assert property (seq_request ##0 (busState == BUS_IDLE) |=> seq_answer)
    else $error("request not answered on the next edge");

  chk_answer_single: assert property (seq_answer |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  chk_reset_clear: assert property ($past(!reset_n) |-> maskFlat == '0)
    else $error("enable bits not zero after reset");

  chk_gate_follow: assert property (monitorSet == $past(eventIn & maskFlat))
    else $error("monitor lanes do not follow gated events");

  chk_gate_quiet: assert property (!$past(maskFlat[B_WDOG_EXPIRED]) |-> !monitorSet[B_WDOG_EXPIRED])
    else $error("watchdog event passed while disabled");

  chk_reserved_zero: assert property ((maskReg[SLOT_REF_AB] & ~REF_WRITABLE) == 8'h00 &&
                                      (maskReg[SLOT_REF_CD] & ~REF_WRITABLE) == 8'h00)
    else $error("reserved enable bit set");

  chk_write_store: assert property (seq_answer ##0 (write && reqMapped && byteenable[0]) |=>
      maskReg[$past(reqSlot)] == ($past(writedata[MASK_W-1:0]) & writableBits($past(reqSlot))))
    else $error("written enable byte not stored");

  chk_hold_idle: assert property (!(write && accepted) |=> $stable(maskFlat))
    else $error("enable bits changed without a write");

  chk_read_back: assert property (seq_answer ##0 (read && reqMapped) |->
      readdata == {{(DATA_W-MASK_W){1'b0}}, maskReg[reqSlot]} && response == RESP_OKAY)
    else $error("read data differs from stored byte");

  chk_decode_error: assert property (seq_answer ##0 !reqMapped |-> response == RESP_DECODE)
    else $error("unmapped access without decode error");

  chk_loop_copy: assert property (write && accepted && reqMapped && byteenable[0] &&
      reqSlot >= SLOT_W'(LOOP_BYTES) |=> maskReg[$past(reqSlot)] == $past(writedata[MASK_W-1:0]))
    else $error("loop group byte not fully writable");

  // ============================================================
  // Lane pairing checks, one named event per check

  // Clock lock loss lane follows its own enable bit
  chk_clk_unlocked: assert property (monitorSet[laneOf(IDX_CLOCK_WDOG_EEPROM, B_CLK_UNLOCKED)] ==
      $past(eventIn[laneOf(IDX_CLOCK_WDOG_EEPROM, B_CLK_UNLOCKED)] &&
            maskReg[slotNum(IDX_CLOCK_WDOG_EEPROM)][B_CLK_UNLOCKED]))
    else $error("clock unlock lane not gated by its enable");

  // Clock calibration start lane
  chk_clk_cal_start: assert property (monitorSet[laneOf(IDX_CLOCK_WDOG_EEPROM, B_CLK_CAL_START)] ==
      $past(eventIn[laneOf(IDX_CLOCK_WDOG_EEPROM, B_CLK_CAL_START)] &&
            maskReg[slotNum(IDX_CLOCK_WDOG_EEPROM)][B_CLK_CAL_START]))
    else $error("clock calibration start lane not gated by its enable");

  // EEPROM fault lane
  chk_eeprom_fault: assert property (monitorSet[laneOf(IDX_CLOCK_WDOG_EEPROM, B_EEPROM_FAULT)] ==
      $past(eventIn[laneOf(IDX_CLOCK_WDOG_EEPROM, B_EEPROM_FAULT)] &&
            maskReg[slotNum(IDX_CLOCK_WDOG_EEPROM)][B_EEPROM_FAULT]))
    else $error("EEPROM fault lane not gated by its enable");

  // EEPROM completion lane
  chk_eeprom_done: assert property (monitorSet[laneOf(IDX_CLOCK_WDOG_EEPROM, B_EEPROM_DONE)] ==
      $past(eventIn[laneOf(IDX_CLOCK_WDOG_EEPROM, B_EEPROM_DONE)] &&
            maskReg[slotNum(IDX_CLOCK_WDOG_EEPROM)][B_EEPROM_DONE]))
    else $error("EEPROM done lane not gated by its enable");

  // Input A fault lane, low nibble
  chk_ref_a_fault: assert property (monitorSet[laneOf(IDX_REF_AB, B_REF_FAULT)] ==
      $past(eventIn[laneOf(IDX_REF_AB, B_REF_FAULT)] &&
            maskReg[slotNum(IDX_REF_AB)][B_REF_FAULT]))
    else $error("input A fault lane not gated by its enable");

  // Input B validated lane, high nibble
  chk_ref_b_valid: assert property (monitorSet[laneOf(IDX_REF_AB, B_REF_VALID + REF_HI_SHIFT)] ==
      $past(eventIn[laneOf(IDX_REF_AB, B_REF_VALID + REF_HI_SHIFT)] &&
            maskReg[slotNum(IDX_REF_AB)][B_REF_VALID + REF_HI_SHIFT]))
    else $error("input B validated lane not gated by its enable");

  // Input C fault cleared lane
  chk_ref_c_clear: assert property (monitorSet[laneOf(IDX_REF_CD, B_REF_CLEARED)] ==
      $past(eventIn[laneOf(IDX_REF_CD, B_REF_CLEARED)] &&
            maskReg[slotNum(IDX_REF_CD)][B_REF_CLEARED]))
    else $error("input C cleared lane not gated by its enable");

  // Input D fault lane
  chk_ref_d_fault: assert property (monitorSet[laneOf(IDX_REF_CD, B_REF_FAULT + REF_HI_SHIFT)] ==
      $past(eventIn[laneOf(IDX_REF_CD, B_REF_FAULT + REF_HI_SHIFT)] &&
            maskReg[slotNum(IDX_REF_CD)][B_REF_FAULT + REF_HI_SHIFT]))
    else $error("input D fault lane not gated by its enable");

  // Loop 0 frequency clamp entry lane
  chk_freq_clamp: assert property (monitorSet[laneOf(IDX_LOOP0_LOCK, B_FREQ_CLAMPED)] ==
      $past(eventIn[laneOf(IDX_LOOP0_LOCK, B_FREQ_CLAMPED)] &&
            maskReg[slotNum(IDX_LOOP0_LOCK)][B_FREQ_CLAMPED]))
    else $error("frequency clamp lane not gated by its enable");

  // Loop 0 slew limit entry lane
  chk_slew_limit: assert property (monitorSet[laneOf(IDX_LOOP0_LOCK, B_SLEW_LIMITED)] ==
      $past(eventIn[laneOf(IDX_LOOP0_LOCK, B_SLEW_LIMITED)] &&
            maskReg[slotNum(IDX_LOOP0_LOCK)][B_SLEW_LIMITED]))
    else $error("slew limit lane not gated by its enable");

  // Loop 0 frequency lock loss lane
  chk_freq_unlock: assert property (monitorSet[laneOf(IDX_LOOP0_LOCK, B_FREQ_UNLOCKED)] ==
      $past(eventIn[laneOf(IDX_LOOP0_LOCK, B_FREQ_UNLOCKED)] &&
            maskReg[slotNum(IDX_LOOP0_LOCK)][B_FREQ_UNLOCKED]))
    else $error("frequency unlock lane not gated by its enable");

  // Loop 0 phase lock gain lane
  chk_phase_lock: assert property (monitorSet[laneOf(IDX_LOOP0_LOCK, B_PHASE_LOCKED)] ==
      $past(eventIn[laneOf(IDX_LOOP0_LOCK, B_PHASE_LOCKED)] &&
            maskReg[slotNum(IDX_LOOP0_LOCK)][B_PHASE_LOCKED]))
    else $error("phase lock lane not gated by its enable");

  // Loop 0 reference switching lane
  chk_ref_switch: assert property (monitorSet[laneOf(IDX_LOOP0_MODE, B_SWITCHING)] ==
      $past(eventIn[laneOf(IDX_LOOP0_MODE, B_SWITCHING)] &&
            maskReg[slotNum(IDX_LOOP0_MODE)][B_SWITCHING]))
    else $error("switching lane not gated by its enable");

  // Loop 0 free-run entry lane
  chk_free_run: assert property (monitorSet[laneOf(IDX_LOOP0_MODE, B_FREE_RUN)] ==
      $past(eventIn[laneOf(IDX_LOOP0_MODE, B_FREE_RUN)] &&
            maskReg[slotNum(IDX_LOOP0_MODE)][B_FREE_RUN]))
    else $error("free-run lane not gated by its enable");

  // Loop 0 history update lane
  chk_history: assert property (monitorSet[laneOf(IDX_LOOP0_MODE, B_HISTORY)] ==
      $past(eventIn[laneOf(IDX_LOOP0_MODE, B_HISTORY)] &&
            maskReg[slotNum(IDX_LOOP0_MODE)][B_HISTORY]))
    else $error("history lane not gated by its enable");

  // Loop 0 input D activation lane
  chk_active_d: assert property (monitorSet[laneOf(IDX_LOOP0_MODE, B_REF_ACTIVE_A + 3)] ==
      $past(eventIn[laneOf(IDX_LOOP0_MODE, B_REF_ACTIVE_A + 3)] &&
            maskReg[slotNum(IDX_LOOP0_MODE)][B_REF_ACTIVE_A + 3]))
    else $error("input D activation lane not gated by its enable");

  // Loop 0 phase step lane
  chk_phase_step: assert property (monitorSet[laneOf(IDX_LOOP0_MISC, B_PHASE_STEP)] ==
      $past(eventIn[laneOf(IDX_LOOP0_MISC, B_PHASE_STEP)] &&
            maskReg[slotNum(IDX_LOOP0_MISC)][B_PHASE_STEP]))
    else $error("phase step lane not gated by its enable");

  // Analog loop calibration start lane
  chk_aloop_go: assert property (monitorSet[laneOf(IDX_LOOP0_MISC, B_ALOOP_CAL_GO)] ==
      $past(eventIn[laneOf(IDX_LOOP0_MISC, B_ALOOP_CAL_GO)] &&
            maskReg[slotNum(IDX_LOOP0_MISC)][B_ALOOP_CAL_GO]))
    else $error("analog calibration lane not gated by its enable");

  // Loop 1 phase lock lane in the first repeated group
  chk_loop1_lock: assert property (monitorSet[laneOf(IDX_LOOP1_FIRST, B_PHASE_LOCKED)] ==
      $past(eventIn[laneOf(IDX_LOOP1_FIRST, B_PHASE_LOCKED)] &&
            maskReg[slotNum(IDX_LOOP1_FIRST)][B_PHASE_LOCKED]))
    else $error("loop 1 lock lane not gated by its enable");

  // Loop 3 phase step lane in the last byte
  chk_loop3_step: assert property (monitorSet[laneOf(IDX_LAST, B_PHASE_STEP)] ==
      $past(eventIn[laneOf(IDX_LAST, B_PHASE_STEP)] &&
            maskReg[slotNum(IDX_LAST)][B_PHASE_STEP]))
    else $error("loop 3 phase step lane not gated by its enable");

endmodule : interrupt_event_mask_bank

// ---- bench/interrupt_event_mask_bank_tb_top.sv ----
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the event mask bank
module interrupt_event_mask_bank_tb_top;
  import event_mask_pkg::*;

  // ============================================================
  // Signals and bench state
  localparam int TIMEOUT = 20000;               // Cycle ceiling, far above the run length
  typedef struct { int unsigned when; logic [EVENT_W-1:0] val; } ev_note_t;
  logic               mclk        = 1'b0;       // 100 MHz clock
  logic               reset_n     = 1'b0;       // Synchronous reset, low active
  logic [ADDR_W-1:0]  address     = '0;         // Bus byte address
  logic               read        = 1'b0;       // Read request
  logic               write       = 1'b0;       // Write request
  logic [3:0]         byteenable  = 4'h0;       // Byte lanes
  logic [DATA_W-1:0]  writedata   = '0;         // Write data
  logic [DATA_W-1:0]  readdata;                 // Read data
  logic [1:0]         response;                 // Response code
  logic               waitrequest;              // Slave stall
  logic [EVENT_W-1:0] eventIn     = '0;         // Raw event lanes
  logic [EVENT_W-1:0] monitorSet;               // Gated event lanes
  logic [EVENT_W-1:0] shadow      = '0;         // Expected enables
  logic [DATA_W-1:0]  rdData[$];                // Expected read data
  logic [1:0]         rdResp[$];                // Expected responses
  ev_note_t           evq[$];                   // Expected gated events
  int unsigned        cyc         = 0;          // Cycle count
  int                 seed;                     // Random seed
  int                 failCount   = 0;          // Mismatches
  int                 checksDone  = 0;          // Comparisons

  // ============================================================
  // Design under test
  interrupt_event_mask_bank dut_u (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .response(response),
    .waitrequest(waitrequest), .eventIn(eventIn), .monitorSet(monitorSet)
  );

  // Clock generator
  always #5 mclk = ~mclk;

  // Cycle counter and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      failCount = failCount + 1;
      completeRun();
    end
  end

  // ============================================================
  // Helpers
  task automatic check(input string what, input logic [EVENT_W-1:0] seen, input logic [EVENT_W-1:0] exp);
    checksDone = checksDone + 1;
    if (seen !== exp) begin
      failCount = failCount + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Byte address of a mask slot
  function automatic logic [ADDR_W-1:0] slotAddr(input int k);
    return {IDX_CLOCK_WDOG_EEPROM + 10'(k), 2'b00};
  endfunction : slotAddr

  // Bits that can be set in a slot
  function automatic logic [7:0] writable(input int k);
    return (k == int'(SLOT_REF_AB) || k == int'(SLOT_REF_CD)) ? REF_WRITABLE : ALL_WRITABLE;
  endfunction : writable

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic [ADDR_W-1:0] a, input logic we, input logic [7:0] v, input logic [3:0] be);
    logic [31:0] rnd;
    rnd = $random(seed);
    @(posedge mclk);
    address    <= a;
    read       <= ~we;
    write      <= we;
    byteenable <= be;
    writedata  <= {rnd[23:0], v};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Write a slot and note the enables it should hold
  task automatic wrSlot(input int k, input logic [7:0] v);
    bus(slotAddr(k), 1'b1, v, 4'h1);
    shadow[8*k +: 8] = v & writable(k);
  endtask : wrSlot

  // Read a slot, expecting the noted enables
  task automatic rdSlot(input int k);
    rdData.push_back({24'h0, shadow[8*k +: 8]});
    rdResp.push_back(RESP_OKAY);
    bus(slotAddr(k), 1'b0, 8'h00, 4'h1);
  endtask : rdSlot

  // Read a refused address
  task automatic rdBad(input logic [ADDR_W-1:0] a);
    rdData.push_back('0);
    rdResp.push_back(RESP_DECODE);
    bus(a, 1'b0, 8'h00, 4'h1);
  endtask : rdBad

  // Drive event lanes and note the gated result two edges on
  task automatic drive(input logic [EVENT_W-1:0] v);
    ev_note_t n;
    @(posedge mclk);
    eventIn <= v;
    n.when = cyc + 2;
    n.val  = v & shadow;
    evq.push_back(n);
  endtask : drive

  // Random event lanes
  task automatic driveRandom();
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    drive(r[EVENT_W-1:0]);
  endtask : driveRandom

  // ============================================================
  // Output watcher: compares the oldest note when a result appears
  always @(posedge mclk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && rdData.size() > 0) begin
      check("readdata", EVENT_W'(readdata), EVENT_W'(rdData.pop_front()));
      check("response", EVENT_W'(response), EVENT_W'(rdResp.pop_front()));
    end
    if (evq.size() > 0 && evq[0].when == cyc) begin
      check("monitorSet", monitorSet, evq[0].val);
      void'(evq.pop_front());
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    seed = 67;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    // Reset values, nothing passes with all events high
    for (int k = 0; k < MASK_COUNT; k++) rdSlot(k);
    drive('1);
    drive('0);
    // Walk one enable bit at a time through every slot
    for (int k = 0; k < MASK_COUNT; k++) begin
      for (int b = 0; b < MASK_W; b++) begin
        wrSlot(k, 8'h01 << b);
        rdSlot(k);
        drive('1);
        drive('0);
      end
      wrSlot(k, 8'h00);
    end
    // Random enables with random event traffic
    repeat (4) begin
      for (int k = 0; k < MASK_COUNT; k++) wrSlot(k, 8'($random(seed)));
      for (int k = 0; k < MASK_COUNT; k++) rdSlot(k);
      repeat (20) driveRandom();
      drive('0);
    end
    // Refused places: below, misaligned, above the bank
    rdBad(12'h438);
    rdBad(12'h43d);
    rdBad(12'h478);
    bus(12'h43e, 1'b1, 8'hff, 4'h1);
    bus(12'h438, 1'b1, 8'hff, 4'h1);
    rdSlot(0);
    // Write with the low lane disabled stores nothing
    bus(slotAddr(3), 1'b1, 8'hff, 4'he);
    rdSlot(3);
    // Second reset clears every enable
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    shadow = '0;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < MASK_COUNT; k++) rdSlot(k);
    drive('1);
    drive('0);
    repeat (4) @(posedge mclk);
    completeRun();
  end

  // Verdict and end of run
  task automatic completeRun();
    $display("Checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : completeRun

endmodule : interrupt_event_mask_bank_tb_top
